// ### include/cycle_watchdog_map.vh
`ifndef CYCLE_WATCHDOG_MAP_VH
`define CYCLE_WATCHDOG_MAP_VH

// Register indices on the plain register port (byte wide data).
`define ADDR_WIDTH          8
`define OFS_CTRL0           8'h00
`define OFS_CTRL1           8'h01
`define OFS_MODEL_OUT       8'h02
`define OFS_MODE            8'h03
`define OFS_PIN_FUNC        8'h04
`define OFS_STATE           8'h05
`define OFS_WARNINGS        8'h06
`define OFS_MODEL_IN        8'h07
`define OFS_FIRMWARE        8'h08
`define OFS_HARDWARE        8'h09
`define OFS_HUMID_BASE      8'h10
`define OFS_PIN_OUT         8'h18
`define OFS_RET_OUT_BASE    8'h40
`define OFS_RET_IN_BASE     8'h80

// Field positions.
`define CTRL1_SAFE_BIT      0
`define CTRL1_COPY_BIT      1
`define CTRL1_PERSIST_BIT   2
`define CTRL1_LEDOFF_BIT    3

// Reset values.
`define CTRL0_RESET         8'h00
`define CTRL1_RESET         8'h00
`define PIN_FUNC_RESET      8'h00
`define HUMID_RESET         16'h0000

// Timing: base timeout 16 ms at 100 MHz clock period 10 ns.
`define CLK_PERIOD_NS       10
`define WDT_BASE_MS         16
`define WDT_BASE_CYCLES     ((`WDT_BASE_MS * 1000000) / `CLK_PERIOD_NS)
`define WDT_MAX_CODE        4'h0A
`define LED_HALF_MS         250
`define LED_HALF_CYCLES     ((`LED_HALF_MS * 1000000) / `CLK_PERIOD_NS)

// Error causes shown in the state byte.
`define CAUSE_NONE          2'h0
`define CAUSE_WATCHDOG      2'h1
`define CAUSE_HOST          2'h2
`define CAUSE_MODEL         2'h3

`endif

// ### rtl/wdt_timer.v
`timescale 1ns/10ps
`include "cycle_watchdog_map.vh"

module wdt_timer #(
  parameter BASE_CYCLES = `WDT_BASE_CYCLES
) (
  input  wire       clk,        // System clock.
  input  wire       rst_b,      // Asynchronous reset, active low.
  input  wire [3:0] sel,        // Timeout select code.
  input  wire       kick,       // One valid exchange cycle seen.
  output reg        expired     // Held high once the gap exceeds the timeout, until a kick.
);

  // Count width covers 8 s, which is 512 times the base period.
  localparam CW = 40;

  reg  [CW-1:0] countReg;
  reg  [CW-1:0] limit;
  wire [3:0]    code;

  // Codes past the table fall back to the longest timeout.
  assign code = (sel > `WDT_MAX_CODE) ? `WDT_MAX_CODE : sel;

  // Limit doubles with each code step from the base.
  always @* begin
    limit = BASE_CYCLES;
    limit = limit << (code - 4'h1);
  end

  // A valid cycle restarts the count; code zero parks it.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      countReg <= {CW{1'b0}};
      expired  <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (sel == 4'h0 || kick) begin
        countReg <= {CW{1'b0}};
      end else if (countReg >= limit) begin
        expired <= 1'b1;
      end else begin
        countReg <= countReg + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // wdt_timer

// ### rtl/led_blinker.v
`timescale 1ns/10ps
`include "cycle_watchdog_map.vh"

module led_blinker #(
  parameter HALF_CYCLES = `LED_HALF_CYCLES
) (
  input  wire       clk,        // System clock.
  input  wire       rst_b,      // Asynchronous reset, active low.
  input  wire       run,        // Blink while high.
  input  wire [1:0] cause,      // Number of flashes per burst.
  output reg        led         // Indicator drive, active high.
);

  reg [31:0] tickReg;
  reg [3:0]  phaseReg;

  // A burst is cause flashes then a dark gap, so the cause can be counted by eye.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickReg  <= 32'h0000_0000;
      phaseReg <= 4'h0;
      led      <= 1'b0;
    end else if (!run) begin
      tickReg  <= 32'h0000_0000;
      phaseReg <= 4'h0;
      led      <= 1'b0;
    end else if (tickReg >= HALF_CYCLES - 1) begin
      tickReg  <= 32'h0000_0000;
      phaseReg <= (phaseReg == 4'h9) ? 4'h0 : phaseReg + 4'h1;
      led      <= (phaseReg[0] == 1'b0) && (phaseReg[3:1] < {1'b0, cause});
    end else begin
      tickReg <= tickReg + 32'h0000_0001;
    end
  end

endmodule // led_blinker

// ### rtl/cycle_watchdog_safe_state.v
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "cycle_watchdog_map.vh"
// Function
// - Sensor humidity held as 16-bit word, zero reset
// - Four humidity words, one per GPIO
// - Pin function byte picks input, output, sensor
// - Persistent area: 64 bytes each direction
// - Restart returns saved bytes if persistence was on
// - Saved copy kept unless persistence enabled again
// - Compare expected model byte, flag mismatch
// - Transfer mode byte ignored
// - Timeout select in byte0 bits 0-3, zero off
// - Codes 1..10 give 16 ms to 8 s
// - Gap longer than timeout enters safe state
// - Invalid cycle does not restart count
// - Safe state turns digital outputs and relays off
// - Safe state floats all PWM outputs
// - Safe state saves persistent data when enabled
// - Indicator flashes error cause pattern when enabled
// - Safe state latched until power cycle
// - Status bytes returned every cycle
// - Persistence enable bit in byte1, reset zero

module cycle_watchdog_safe_state #(
  parameter       WDT_BASE  = `WDT_BASE_CYCLES,  // Cycles for the 16 ms base timeout.
  parameter       LED_HALF  = `LED_HALF_CYCLES,  // Cycles per indicator half period.
  parameter [7:0] MODEL_ID  = 8'h5A,             // Own model identity, arbitrary value.
  parameter [7:0] FW_VER    = 8'h01,             // Firmware version, arbitrary value.
  parameter [7:0] HW_VER    = 8'h01,             // Hardware version, arbitrary value.
  parameter       NUM_DOUT  = 16,                // Digital output and relay count.
  parameter       NUM_PWM   = 4                  // PWM channel count.
) (
  input  wire                   clk,           // System clock, 100 MHz.
  input  wire                   rst_b,         // Power-up reset, active low.
  input  wire [`ADDR_WIDTH-1:0] regAddr,       // Register index.
  input  wire [7:0]             regWdata,      // Write data.
  input  wire                   regWr,         // Write strobe.
  input  wire                   regRd,         // Read strobe.
  output reg  [7:0]             regRdata,      // Read data, one cycle after the strobe.
  input  wire                   cycleDone,     // Pulse at the end of an exchange cycle.
  input  wire                   cycleValid,    // Checksum of that cycle was good.
  input  wire [63:0]            humidIn,       // Four measured humidity words.
  input  wire [3:0]             humidStb,      // Per channel new measurement pulse.
  input  wire [NUM_DOUT-1:0]    doutReq,       // Digital output values from the host path.
  input  wire [NUM_PWM-1:0]     pwmReq,        // PWM waveforms from the PWM logic.
  input  wire                   powerFail,     // Supply is going down, raw pin.
  input  wire [511:0]           savedData,     // Backed up persistent bytes at restart.
  input  wire                   savedValid,    // Backup holds a valid copy, raw pin.
  output reg  [NUM_DOUT-1:0]    doutDrive,     // Digital outputs and relay drives.
  output reg  [NUM_PWM-1:0]     pwmOut,        // PWM output values.
  output reg  [NUM_PWM-1:0]     pwmOe,         // PWM output enables, high while driven.
  output reg  [3:0]             pinDir,        // GPIO output enables.
  output reg  [3:0]             pinSensor,     // GPIO sensor mode flags.
  output reg                    saveStrobe,    // Pulse: store persistentOut to backup.
  output reg  [511:0]           persistentOut, // Persistent output area to back up.
  output reg                    safeState,     // Latched safe state flag.
  output reg                    statusLed      // Status indicator drive.
);

  // Register file.
  reg [7:0]   ctrl0_reg;
  reg [7:0]   ctrl1_reg;
  reg [7:0]   expected_model_byte_reg;
  reg [7:0]   pinFunc_reg;
  reg [7:0]   pinOut_reg;
  reg [15:0]  humid_reg [0:3];
  reg [7:0]   retOut_reg [0:63];
  reg [7:0]   retIn_reg [0:63];
  reg [7:0]   retCopy_reg [0:63];
  reg         modelSeen_reg;
  reg         modelErr_reg;
  reg [1:0]   cause_reg;
  reg         savedDone_reg;
  reg [1:0]   pfSync_reg;
  reg [1:0]   svSync_reg;
  reg         restoreDone_reg;
  reg [1:0]   bootCnt_reg;
  reg [7:0]   rdata_next;

  wire        wdtExpire;
  wire        persistOn;
  wire        hostSafe;
  wire        pfLevel;
  wire        svLevel;
  wire [1:0]  ledCause;
  wire        ledRun;
  wire        gateOff;

  integer i;
  genvar  g;

  // Decode of a register index inside a window of the given size.
  function inWin;
    input [`ADDR_WIDTH-1:0] a;
    input [`ADDR_WIDTH-1:0] base;
    input [`ADDR_WIDTH-1:0] size;
    begin
      inWin = (a >= base) && (a < base + size);
    end
  endfunction

  assign persistOn = ctrl1_reg[`CTRL1_PERSIST_BIT];
  assign hostSafe  = ctrl1_reg[`CTRL1_SAFE_BIT];
  assign pfLevel   = pfSync_reg[1];
  assign svLevel   = svSync_reg[1];
  assign ledCause  = cause_reg;
  assign ledRun    = safeState && !ctrl1_reg[`CTRL1_LEDOFF_BIT];
  // Outputs drop on the same edge that the safe state is entered, whatever the cause.
  assign gateOff   = safeState || wdtExpire || hostSafe;

  // Only a valid cycle counts as a kick; a bad checksum looks like silence.
  wdt_timer #(
    .BASE_CYCLES (WDT_BASE)
  ) u_wdt (
    .clk     (clk),
    .rst_b   (rst_b),
    .sel     (ctrl0_reg[3:0]),
    .kick    (cycleDone && cycleValid),
    .expired (wdtExpire)
  );

  led_blinker #(
    .HALF_CYCLES (LED_HALF)
  ) u_led (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (ledRun),
    .cause (ledCause),
    .led   (statusLed)
  );

  // Two-flop synchronisers for the supply monitor and backup valid pins.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pfSync_reg <= 2'b00;
      svSync_reg <= 2'b00;
    end else begin
      pfSync_reg <= {pfSync_reg[0], powerFail};
      svSync_reg <= {svSync_reg[0], savedValid};
    end
  end

  // Control bytes; the transfer mode byte has no storage at all.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_reg     <= `CTRL0_RESET;
      ctrl1_reg     <= `CTRL1_RESET;
      expected_model_byte_reg  <= 8'h00;
      modelSeen_reg <= 1'b0;
      pinFunc_reg   <= `PIN_FUNC_RESET;
      pinOut_reg    <= 8'h00;
    end else if (regWr) begin
      case (regAddr)
        `OFS_CTRL0: begin
          ctrl0_reg <= {4'h0, regWdata[3:0]};
        end
        `OFS_CTRL1: begin
          ctrl1_reg <= {3'b000, regWdata[4:0]};
        end
        `OFS_MODEL_OUT: begin
          expected_model_byte_reg  <= regWdata;
          modelSeen_reg <= 1'b1;
        end
        `OFS_PIN_FUNC: begin
          pinFunc_reg <= regWdata;
        end
        `OFS_PIN_OUT: begin
          pinOut_reg <= {4'h0, regWdata[3:0]};
        end
        default: begin
          ctrl0_reg <= ctrl0_reg;
        end
      endcase
    end
  end

  // Sensor results land only on channels in sensor mode.
  generate
    for (g = 0; g < 4; g = g + 1) begin : gHumid
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          humid_reg[g] <= `HUMID_RESET;
        end else if (humidStb[g] && pinFunc_reg[4+g]) begin
          humid_reg[g] <= humidIn[16*g +: 16];
        end
      end
    end
  endgenerate

  // Output area written by the host, input area restored after restart.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 64; i = i + 1) begin
        retOut_reg[i]  <= 8'h00;
        retIn_reg[i]   <= 8'h00;
        retCopy_reg[i] <= 8'h00;
      end
      restoreDone_reg <= 1'b0;
      bootCnt_reg     <= 2'b00;
    end else begin
      if (regWr && inWin(regAddr, `OFS_RET_OUT_BASE, 8'd64)) begin
        retOut_reg[regAddr[5:0]] <= regWdata;
      end
      // Copy mode mirrors the output area one exchange cycle late.
      if (cycleDone && cycleValid) begin
        for (i = 0; i < 64; i = i + 1) begin
          retCopy_reg[i] <= retOut_reg[i];
        end
      end
      // Backup is read once the valid synchroniser has settled, since it starts at zero.
      if (!restoreDone_reg) begin
        bootCnt_reg <= bootCnt_reg + 2'b01;
        if (bootCnt_reg == 2'b10) begin
          restoreDone_reg <= 1'b1;
          for (i = 0; i < 64; i = i + 1) begin
            retIn_reg[i] <= svLevel ? savedData[8*i +: 8] : 8'h00;
          end
        end
      end
    end
  end

  // Flatten the output area for the backup store.
  always @* begin
    persistentOut = 512'h0;
    for (i = 0; i < 64; i = i + 1) begin
      persistentOut[8*i +: 8] = retOut_reg[i];
    end
  end

  // Model check after the host has written its expectation.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modelErr_reg <= 1'b0;
    end else begin
      modelErr_reg <= modelSeen_reg && (expected_model_byte_reg != MODEL_ID);
    end
  end

  // Safe state latches; nothing but reset by power cycle releases it.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      safeState <= 1'b0;
      cause_reg <= `CAUSE_NONE;
    end else if (!safeState && (wdtExpire || hostSafe)) begin
      safeState <= 1'b1;
      cause_reg <= wdtExpire ? `CAUSE_WATCHDOG : `CAUSE_HOST;
    end
  end

  // One save on entry to safe state or on power loss, only with persistence on.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      saveStrobe    <= 1'b0;
      savedDone_reg <= 1'b0;
    end else begin
      saveStrobe <= 1'b0;
      if (persistOn && !savedDone_reg && (safeState || pfLevel)) begin
        saveStrobe    <= 1'b1;
        savedDone_reg <= 1'b1;
      end
    end
  end

  // Output gating: digital outputs idle and PWM floated in safe state.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      doutDrive <= {NUM_DOUT{1'b0}};
      pwmOut    <= {NUM_PWM{1'b0}};
      pwmOe     <= {NUM_PWM{1'b0}};
      pinDir    <= 4'h0;
      pinSensor <= 4'h0;
    end else begin
      doutDrive <= gateOff ? {NUM_DOUT{1'b0}} : doutReq;
      pwmOut    <= gateOff ? {NUM_PWM{1'b0}} : pwmReq;
      pwmOe     <= gateOff ? {NUM_PWM{1'b0}} : {NUM_PWM{1'b1}};
      pinSensor <= pinFunc_reg[7:4];
      pinDir    <= gateOff ? 4'h0 : (pinFunc_reg[3:0] & ~pinFunc_reg[7:4]);
    end
  end

  // Read mux; unmapped indices and write-only bytes read as zero.
  always @* begin
    rdata_next = 8'h00;
    case (regAddr)
      `OFS_CTRL0:    rdata_next = ctrl0_reg;
      `OFS_CTRL1:    rdata_next = ctrl1_reg;
      `OFS_PIN_FUNC: rdata_next = pinFunc_reg;
      `OFS_PIN_OUT:  rdata_next = pinOut_reg;
      `OFS_STATE:    rdata_next = {4'h0, modelErr_reg, cause_reg, safeState};
      `OFS_WARNINGS: rdata_next = {6'h00, persistOn, restoreDone_reg & svLevel};
      `OFS_MODEL_IN: rdata_next = MODEL_ID;
      `OFS_FIRMWARE: rdata_next = FW_VER;
      `OFS_HARDWARE: rdata_next = HW_VER;
      default: begin
        if (inWin(regAddr, `OFS_HUMID_BASE, 8'd8)) begin
          rdata_next = regAddr[0] ? humid_reg[regAddr[2:1]][15:8] : humid_reg[regAddr[2:1]][7:0];
        end else if (inWin(regAddr, `OFS_RET_IN_BASE, 8'd64)) begin
          rdata_next = ctrl1_reg[`CTRL1_COPY_BIT] ? retCopy_reg[regAddr[5:0]] : retIn_reg[regAddr[5:0]];
        end
      end
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRd ? rdata_next : 8'h00;
    end
  end

endmodule // cycle_watchdog_safe_state

// ### bench/cycle_watchdog_safe_state_assertions.sv
`timescale 1ns/10ps
module cycle_watchdog_checker #(
  parameter NUM_DOUT = 16, // Digital output count.
  parameter NUM_PWM  = 4   // PWM channel count.
) (
  input wire                clk,        // Clock.
  input wire                rst_b,      // Reset, active low.
  input wire [7:0]          regAddr,    // Register index.
  input wire [7:0]          regWdata,   // Write data.
  input wire                regWr,      // Write strobe.
  input wire                regRd,      // Read strobe.
  input wire [7:0]          regRdata,   // Read data.
  input wire [NUM_DOUT-1:0] doutReq,    // Requested outputs.
  input wire [NUM_DOUT-1:0] doutDrive,  // Output drives.
  input wire [NUM_PWM-1:0]  pwmOe,      // PWM enables.
  input wire                saveStrobe, // Backup pulse.
  input wire                safeState   // Safe state flag.
);
  reg persistOn;
  // Shadow of the persistence enable, so that every save can be tied to it.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) persistOn <= 1'b0;
    else if (regWr && regAddr == 8'h01) persistOn <= regWdata[2];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence rdMode; regRd && regAddr == 8'h03; endsequence
  sequence goSafe; !safeState ##1 safeState; endsequence
  // Nothing but a power cycle may clear the safe state.
  safe_latched_a: assert property (safeState |=> safeState)
    else $error("safe state released");
  outputs_off_a: assert property (safeState |-> doutDrive == '0)
    else $error("outputs driven in safe state");
  pwm_float_a: assert property (safeState |-> pwmOe == '0)
    else $error("pwm driven in safe state");
  // The first edge after reset still shows reset values, hence the past reset term.
  dout_follow_a: assert property ($past(rst_b) && !safeState |-> doutDrive == $past(doutReq) && pwmOe == '1)
    else $error("outputs not following request");
  mode_ignored_a: assert property (rdMode |=> regRdata == 8'h00)
    else $error("mode byte not zero");
  save_pulse_a: assert property (goSafe ##0 persistOn |=> saveStrobe)
    else $error("no save on safe entry");
  save_needs_persist_a: assert property (saveStrobe |-> persistOn)
    else $error("save without persistence");
  save_once_a: assert property (saveStrobe |=> !saveStrobe)
    else $error("save pulse too long");
endmodule // cycle_watchdog_checker
bind cycle_watchdog_safe_state cycle_watchdog_checker #(.NUM_DOUT(NUM_DOUT), .NUM_PWM(NUM_PWM)) chk (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .doutReq(doutReq), .doutDrive(doutDrive), .pwmOe(pwmOe),
  .saveStrobe(saveStrobe), .safeState(safeState));

// ### bench/host_cycle_model.sv
`timescale 1ns/10ps
module host_cycle_model (
  input  wire       clk,       // Clock.
  input  wire       rst_b,     // Reset, active low.
  input  wire       run,       // Send exchange cycles while high.
  input  wire       good,      // Checksum of sent cycles is good.
  input  wire [7:0] gap,       // Clocks between two cycle ends, less one.
  output reg        cycleDone, // End of cycle pulse.
  output reg        cycleValid // Checksum good, beside cycleDone.
);
  reg [7:0] cntReg;
  // Between cycle ends the valid line toggles, so the block cannot lean on a stale level.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cntReg <= 8'h00;
      cycleDone <= 1'b0;
      cycleValid <= 1'b0;
    end else begin
      cntReg <= (run && cntReg < gap) ? cntReg + 8'h01 : 8'h00;
      cycleDone <= run && cntReg == gap;
      cycleValid <= (run && cntReg == gap) ? good : ~cycleValid;
    end
  end
endmodule // host_cycle_model

// ### bench/cycle_watchdog_safe_state_bench.sv
`timescale 1ns/10ps
module cycle_watchdog_safe_state_bench;
  localparam BASE = 4;
  localparam [7:0] MID = 8'h5A; // Model identity, arbitrary value.
  reg          clk, rst_b, regWr, regRd, run, good, powerFail, savedValid, rdSeen;
  reg  [7:0]   regAddr, regWdata, gap, d;
  reg  [63:0]  humidIn;
  reg  [3:0]   humidStb, pwmReq;
  reg  [15:0]  doutReq, hw;
  reg  [511:0] savedData, pexp;
  wire [7:0]   regRdata;
  wire [15:0]  doutDrive;
  wire [3:0]   pwmOut, pwmOe, pinDir, pinSensor;
  wire [511:0] persistentOut;
  wire         cycleDone, cycleValid, saveStrobe, safeState, statusLed;
  integer      err_count, tests_run, i, n, saves, lim;
  reg  [7:0]   expQ[$];

  cycle_watchdog_safe_state #(.WDT_BASE(BASE), .LED_HALF(2), .MODEL_ID(MID), .FW_VER(8'h21), .HW_VER(8'h13)) uut (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cycleDone(cycleDone), .cycleValid(cycleValid), .humidIn(humidIn),
    .humidStb(humidStb), .doutReq(doutReq), .pwmReq(pwmReq), .powerFail(powerFail), .savedData(savedData),
    .savedValid(savedValid), .doutDrive(doutDrive), .pwmOut(pwmOut), .pwmOe(pwmOe), .pinDir(pinDir),
    .pinSensor(pinSensor), .saveStrobe(saveStrobe), .persistentOut(persistentOut), .safeState(safeState),
    .statusLed(statusLed));
  host_cycle_model host (.clk(clk), .rst_b(rst_b), .run(run), .good(good), .gap(gap),
    .cycleDone(cycleDone), .cycleValid(cycleValid));

  always #5 clk = ~clk;

  task check(input [511:0] seen, input [511:0] exp, input [8*10:1] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  // A strobe is dropped and an idle cycle passes, so no signal is assigned twice in one step.
  task wr(input [7:0] a, input [7:0] v);
    begin
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
    end
  endtask

  task doReset;
    begin
      rst_b <= 1'b0;
      run <= 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      saves = 0;
      repeat (2) @(posedge clk);
    end
  endtask

  // Read data stand one cycle only, so each answer is judged at the edge closing that cycle.
  always @(posedge clk) begin
    if (rdSeen) check(regRdata, expQ.size() ? expQ.pop_front() : 8'hEE, "regRdata");
    rdSeen <= regRd;
    doutReq <= 16'($urandom);
    pwmReq <= 4'($urandom);
    if (saveStrobe === 1'b1) saves = saves + 1;
  end

  // The watchdog is armed with a code and the time to the safe state is measured.
  task wdCase(input [3:0] code, input [7:0] ctrl1);
    begin
      doReset;
      wr(8'h01, ctrl1);
      wr(8'h00, {4'h0, code});
      lim = BASE << ((code > 4'hA ? 10 : code) - 1);
      n = 0;
      while (safeState !== 1'b1 && n < lim + 20) begin
        @(posedge clk);
        n = n + 1;
      end
      check(n >= lim && n <= lim + 4, 1'b1, "wdTime");
    end
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {regWr, regRd, run, powerFail, savedValid, rdSeen} = 6'h00;
    {regAddr, regWdata, humidStb, doutReq, pwmReq} = '0;
    good = 1'b1;
    gap = 8'h05;
    err_count = 0;
    tests_run = 0;
    i = $urandom(32'he145_527d);
    humidIn = {$urandom, $urandom};
    savedData = {16{$urandom}};
    doReset;
    // Development phase: the watchdog stays off and host pauses are harmless.
    repeat (100) @(posedge clk);
    check(safeState, 1'b0, "wdOff");
    rd(8'h00, 8'h00);
    rd(8'h07, MID);
    rd(8'h08, 8'h21);
    rd(8'h09, 8'h13);
    wr(8'h03, 8'($urandom));
    rd(8'h03, 8'h00);
    rd(8'hF0, 8'h00);
    for (i = 0; i < 8; i = i + 1) rd(8'h10 + i, 8'h00);
    wr(8'h04, 8'h2C);
    @(posedge clk);
    check({pinSensor, pinDir}, 8'h2C, "pinFunc");
    humidStb <= 4'hF;
    @(posedge clk);
    humidStb <= 4'h0;
    @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      hw = (i >> 1) == 1 ? humidIn[31:16] : 16'h0000;
      rd(8'h10 + i, i[0] ? hw[15:8] : hw[7:0]);
    end
    wr(8'h02, 8'h51);
    rd(8'h05, 8'h08);
    wr(8'h02, MID);
    rd(8'h05, 8'h00);
    for (i = 0; i < 64; i = i + 1) begin
      d = 8'($urandom);
      pexp[8*i +: 8] = d;
      wr(8'h40 + i, d);
    end
    check(persistentOut, pexp, "persistOut");
    rd(8'h7F, 8'h00);
    rd(8'h80, 8'h00);
    rd(8'hBF, 8'h00);
    // Valid cycles keep the watchdog quiet, bad checksums do not.
    wr(8'h00, 8'h02);
    run <= 1'b1;
    repeat (80) @(posedge clk);
    check(safeState, 1'b0, "kicked");
    good <= 1'b0;
    repeat (20) @(posedge clk);
    check(safeState, 1'b1, "badCycle");
    good <= 1'b1;
    for (i = 1; i < 13; i = i + 1) wdCase(i[3:0], 8'h00);
    // A restart with a valid backup presents the saved bytes once the pin has settled.
    savedValid <= 1'b1;
    doReset;
    repeat (2) @(posedge clk);
    rd(8'h80, savedData[7:0]);
    rd(8'hBF, savedData[511:504]);
    rd(8'h06, 8'h01);
    savedValid <= 1'b0;
    wdCase(4'h1, 8'h04);
    repeat (3) @(posedge clk);
    check({doutDrive, pwmOe, pwmOut}, 24'h00_0000, "safeOuts");
    check(saves, 1, "saves");
    rd(8'h05, 8'h03);
    rd(8'h06, 8'h02);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    n = 0;
    d = {7'h00, statusLed};
    repeat (40) begin
      @(posedge clk);
      if (statusLed !== d[0]) n = n + 1;
      d = {7'h00, statusLed};
    end
    check(n > 0, 1'b1, "ledBlink");
    check(safeState, 1'b1, "latched");
    tally_and_finish;
  end
endmodule // cycle_watchdog_safe_state_bench
